// ---- logic/mmap_pkg.sv ----
// Shared constants and types of the memory space address mapper.
// Assumes an 8-bit CPU with 16-bit CODE and XDATA addresses.
package mmap_pkg;

    // ------------------------------------------------------------
    // XDATA and unified CODE windows
    // ------------------------------------------------------------
    localparam logic [15:0] XD_RADIO_BASE = 16'hDF00;
    localparam logic [15:0] XD_SFR_BASE   = 16'hDF80;
    localparam logic [15:0] XD_SRAM_BASE  = 16'hE000;
    localparam logic [15:0] XD_RET_BASE   = 16'hF000;
    localparam logic [4:0]  DATA_PAGE     = 5'h1F;
    localparam logic [7:0]  DATA_DIR_LIM  = 8'h80;
    localparam logic [7:0]  SFR_BASE      = 8'h80;

    // ------------------------------------------------------------
    // Memory control register
    // ------------------------------------------------------------
    localparam logic [6:0] MCR_IDX      = 7'h47;
    localparam int         MCR_UNIF_BIT = 6;
    localparam int         MCR_BANK_LSB = 4;
    localparam logic [7:0] MCR_RESET    = 8'h00;

    typedef enum logic [2:0] {
        TGT_NONE  = 3'h0,
        TGT_FLASH = 3'h1,
        TGT_SRAM  = 3'h2,
        TGT_SFR   = 3'h3,
        TGT_RADIO = 3'h4
    } mmap_tgt_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_ISSUE = 2'h1,
        ST_WAIT  = 2'h3
    } mmap_st_e;

    // Registers kept inside the CPU core; reachable only by direct
    // addressing, never through the XDATA or CODE window.
    function automatic logic is_cpu_sfr(input logic [6:0] idx);
        case ({1'b1, idx})
            8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h87,
            8'h92, 8'h93, 8'h9A, 8'hA8, 8'hA9, 8'hB8,
            8'hB9, 8'hC0, 8'hD0, 8'hE0, 8'hE8, 8'hF0: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

endpackage

// ---- logic/mmap_sram.sv ----
// The 8 KB SRAM array with a registered read port.
// Assumes one access per enable pulse; contents are not reset.
`timescale 1ns/10ps
`default_nettype none
module mmap_sram #(
    parameter int AW = 13,
    parameter int DW = 8
) (
    input  wire logic          i_clk,
    input  wire logic          i_resetn,
    input  wire logic          i_en,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [DW-1:0] i_wdata,
    output logic      [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rdata_ff;

    if (AW < 8 || DW < 1) begin : g_bad
        $error("mmap_sram: AW must cover the 256-byte data page");
    end

    always_ff @(posedge i_clk) begin
        if (i_en && i_we) begin
            mem[i_addr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_ff <= '0;
        end else if (i_en && !i_we) begin
            rdata_ff <= mem[i_addr];
        end
    end

    assign o_rdata = rdata_ff;
endmodule
`default_nettype wire

// ---- logic/mmap_sfr.sv ----
// Register-space port: holds the memory control register, forms
// single-bit accesses and guards the CPU-internal registers.
// Assumes the external register file answers one cycle after a strobe.
`timescale 1ns/10ps
`default_nettype none
module mmap_sfr (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_go,
    input  wire logic       i_we,
    input  wire logic [6:0] i_idx,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_bit,
    input  wire logic [2:0] i_bitsel,
    input  wire logic       i_window,
    output logic            o_sfr_rd,
    output logic            o_sfr_wr,
    output logic      [7:0] o_sfr_addr,
    output logic      [7:0] o_sfr_wdata,
    output logic      [7:0] o_sfr_wmask,
    output logic            o_local,
    output logic      [7:0] o_local_rdata,
    output logic            o_unified,
    output logic      [1:0] o_bank
);
    logic [7:0] mcr_ff;
    logic       rd_ff, wr_ff, local_ff;
    logic [7:0] addr_ff, wdata_ff, wmask_ff, lrd_ff;

    wire       bad_bit = i_bit && (i_idx[2:0] != 3'h0);
    wire       hidden  = i_window && mmap_pkg::is_cpu_sfr(i_idx);
    wire       bad     = bad_bit || hidden;
    wire       is_mcr  = (i_idx == mmap_pkg::MCR_IDX);
    wire       local_h = bad || is_mcr;
    wire [7:0] mask    = i_bit ? (8'h01 << i_bitsel) : 8'hFF;
    wire [7:0] wd      = i_bit ? {8{i_wdata[0]}} : i_wdata;
    wire       mcr_wr  = i_go && i_we && is_mcr && !bad;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mcr_ff <= mmap_pkg::MCR_RESET;
        end else if (mcr_wr) begin
            mcr_ff <= (mcr_ff & ~mask) | (wd & mask);
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_ff    <= 1'b0;
            wr_ff    <= 1'b0;
            local_ff <= 1'b0;
            addr_ff  <= '0;
            wdata_ff <= '0;
            wmask_ff <= '0;
            lrd_ff   <= '0;
        end else begin
            rd_ff <= i_go && !i_we && !local_h;
            wr_ff <= i_go && i_we && !local_h;
            if (i_go) begin
                local_ff <= local_h;
                addr_ff  <= {1'b1, i_idx};
                wdata_ff <= wd;
                wmask_ff <= mask;
                lrd_ff   <= bad ? 8'h00 : mcr_ff;
            end
        end
    end

    assign o_sfr_rd      = rd_ff;
    assign o_sfr_wr      = wr_ff;
    assign o_sfr_addr    = addr_ff;
    assign o_sfr_wdata   = wdata_ff;
    assign o_sfr_wmask   = wmask_ff;
    assign o_local       = local_ff;
    assign o_local_rdata = lrd_ff;
    assign o_unified     = mcr_ff[mmap_pkg::MCR_UNIF_BIT];
    assign o_bank        = mcr_ff[mmap_pkg::MCR_BANK_LSB +: 2];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_bit_mask: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_go && i_we && i_bit && !local_h)
        |=> o_sfr_wr && o_sfr_wmask == (8'h01 << $past(i_bitsel)))
        else $error("single-bit write mask wrong");
    a_hidden_regs: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_go && hidden) |=> !o_sfr_rd && !o_sfr_wr && o_local_rdata == 8'h00)
        else $error("CPU-internal register reached through window");
endmodule
`default_nettype wire

// ---- logic/mmap_top.sv ----
// Memory space address mapper: decodes CODE, DATA, XDATA and register
// accesses of the CPU and DMA masters onto flash, SRAM and registers.
// Assumes flash, radio and register files answer one cycle after their
// strobe, and that each master holds its request until its ack.
`timescale 1ns/10ps
`default_nettype none
module mmap_top #(
    parameter int FLASH_KB = 128
) (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_deepest_low_power_modes,
    input  wire logic        i_code_req,
    input  wire logic [15:0] i_code_addr,
    output logic             o_code_ack,
    output logic      [7:0]  o_code_rdata,
    output logic             o_code_stall,
    input  wire logic        i_xc_req,
    input  wire logic        i_xc_we,
    input  wire logic [15:0] i_xc_addr,
    input  wire logic [7:0]  i_xc_wdata,
    output logic             o_xc_ack,
    output logic      [7:0]  o_xc_rdata,
    input  wire logic        i_dma_req,
    input  wire logic        i_dma_we,
    input  wire logic [15:0] i_dma_addr,
    input  wire logic [7:0]  i_dma_wdata,
    output logic             o_dma_ack,
    output logic      [7:0]  o_dma_rdata,
    input  wire logic        i_data_req,
    input  wire logic        i_data_we,
    input  wire logic [7:0]  i_data_addr,
    input  wire logic        i_data_indirect,
    input  wire logic        i_data_bit,
    input  wire logic [2:0]  i_data_bitsel,
    input  wire logic [7:0]  i_data_wdata,
    output logic             o_data_ack,
    output logic      [7:0]  o_data_rdata,
    output logic             o_flash_rd,
    output logic      [16:0] o_flash_addr,
    input  wire logic [7:0]  i_flash_rdata,
    output logic             o_radio_rd,
    output logic             o_radio_wr,
    output logic      [6:0]  o_radio_addr,
    output logic      [7:0]  o_radio_wdata,
    input  wire logic [7:0]  i_radio_rdata,
    output logic             o_sfr_rd,
    output logic             o_sfr_wr,
    output logic      [7:0]  o_sfr_addr,
    output logic      [7:0]  o_sfr_wdata,
    output logic      [7:0]  o_sfr_wmask,
    input  wire logic [7:0]  i_sfr_rdata,
    output logic             o_unified_code_map_select,
    output logic      [1:0]  o_flash_bank_select
);
    if (FLASH_KB != 32 && FLASH_KB != 64 && FLASH_KB != 128) begin : g_bad
        $error("mmap_top: FLASH_KB must be 32, 64 or 128");
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Returns {target, offset}; the offset is the flash byte address,
    // the SRAM index or, in its low seven bits, the register index.
    function automatic logic [19:0] f_decode(
        input logic [15:0] a,
        input logic        code,
        input logic        unif,
        input logic [1:0]  bank
    );
        mmap_pkg::mmap_tgt_e t;
        logic [16:0]         o;
        t = mmap_pkg::TGT_FLASH;
        o = {1'b0, a};
        if (code && !unif) begin
            if (FLASH_KB == 32 && a[15]) begin
                t = mmap_pkg::TGT_NONE;
            end else if (FLASH_KB == 128) begin
                o = a[15] ? {bank, a[14:0]} : {2'b00, a[14:0]};
            end
        end else if (a >= mmap_pkg::XD_SRAM_BASE) begin
            t = mmap_pkg::TGT_SRAM;
            o = {4'h0, a[12:0]};
        end else if (a >= mmap_pkg::XD_SFR_BASE) begin
            t = mmap_pkg::TGT_SFR;
        end else if (a >= mmap_pkg::XD_RADIO_BASE) begin
            t = mmap_pkg::TGT_RADIO;
        end else if (FLASH_KB == 32 && a[15]) begin
            t = mmap_pkg::TGT_NONE;
        end else if (code && FLASH_KB == 128 && a[15]) begin
            o = {bank, a[14:0]};
        end
        return {t, o};
    endfunction

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    mmap_pkg::mmap_st_e st_ff, nxt_st;
    logic [3:0]  mst_ff;
    logic [2:0]  tgt_ff;
    logic        rd_ff, bit_ff;
    logic [2:0]  bitsel_ff;
    logic        flash_rd_ff, radio_rd_ff, radio_wr_ff;
    logic [16:0] flash_addr_ff;
    logic [6:0]  radio_addr_ff;
    logic [7:0]  radio_wdata_ff;
    logic [3:0]  ack_ff;
    logic [7:0]  code_rd_ff, xc_rd_ff, dma_rd_ff, data_rd_ff;
    logic        stall_ff;
    logic [7:0]  sram_rdata, sfr_lrdata;
    logic        sfr_local, unified;
    logic [1:0]  bank;

    // The deepest low-power modes hold back new grants, so the retained SRAM half
    // cannot be disturbed while the rest of the chip is unpowered.
    wire idle   = (st_ff == mmap_pkg::ST_IDLE) && !i_deepest_low_power_modes;
    wire g_dma  = idle && i_dma_req && !ack_ff[2];
    wire g_xc   = idle && i_xc_req && !ack_ff[1] && !g_dma;
    wire g_data = idle && i_data_req && !ack_ff[3] && !g_dma && !g_xc;
    wire g_code = idle && i_code_req && !ack_ff[0] && !g_dma && !g_xc
                  && !g_data && !(i_xc_req && !ack_ff[1]);
    wire g_any  = g_dma || g_xc || g_data || g_code;

    wire [15:0] x_addr  = g_dma ? i_dma_addr : i_xc_addr;
    wire [15:0] a_sel   = g_code ? i_code_addr : x_addr;
    wire [19:0] dec     = f_decode(a_sel, g_code, unified, bank);
    wire [7:0]  x_wdata = g_dma ? i_dma_wdata : i_xc_wdata;
    wire        data_rf = !i_data_indirect && (i_data_addr >= mmap_pkg::DATA_DIR_LIM);
    wire [2:0]  tgt     = g_data ? (data_rf ? mmap_pkg::TGT_SFR
                                            : mmap_pkg::TGT_SRAM)
                                 : dec[19:17];
    wire        we      = g_dma ? i_dma_we : g_xc ? i_xc_we
                        : g_data ? i_data_we : 1'b0;
    wire [7:0]  wdata   = g_data ? i_data_wdata : x_wdata;
    wire [12:0] sram_a  = g_data ? {mmap_pkg::DATA_PAGE, i_data_addr}
                                 : dec[12:0];
    wire [6:0]  sfr_idx = g_data ? i_data_addr[6:0] : dec[6:0];
    wire        bit_acc = g_data && data_rf && i_data_bit;
    wire        go_sram = g_any && tgt == mmap_pkg::TGT_SRAM;
    wire        go_sfr  = g_any && tgt == mmap_pkg::TGT_SFR;
    wire        go_fl   = g_any && tgt == mmap_pkg::TGT_FLASH && !we;
    wire        go_rad  = g_any && tgt == mmap_pkg::TGT_RADIO;
    wire [3:0]  mst     = {g_data, g_dma, g_xc, g_code};

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            mmap_pkg::ST_IDLE:  if (g_any) nxt_st = mmap_pkg::ST_ISSUE;
            mmap_pkg::ST_ISSUE: nxt_st = mmap_pkg::ST_WAIT;
            mmap_pkg::ST_WAIT:  nxt_st = mmap_pkg::ST_IDLE;
            default:            nxt_st = mmap_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Issue stage
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_ff          <= mmap_pkg::ST_IDLE;
            mst_ff         <= '0;
            tgt_ff         <= mmap_pkg::TGT_NONE;
            rd_ff          <= 1'b0;
            bit_ff         <= 1'b0;
            bitsel_ff      <= '0;
            flash_rd_ff    <= 1'b0;
            radio_rd_ff    <= 1'b0;
            radio_wr_ff    <= 1'b0;
            flash_addr_ff  <= '0;
            radio_addr_ff  <= '0;
            radio_wdata_ff <= '0;
        end else begin
            st_ff       <= nxt_st;
            flash_rd_ff <= go_fl;
            radio_rd_ff <= go_rad && !we;
            radio_wr_ff <= go_rad && we;
            if (g_any) begin
                mst_ff         <= mst;
                tgt_ff         <= tgt;
                rd_ff          <= !we;
                bit_ff         <= bit_acc;
                bitsel_ff      <= i_data_bitsel;
                flash_addr_ff  <= dec[16:0];
                radio_addr_ff  <= dec[6:0];
                radio_wdata_ff <= wdata;
            end
        end
    end

    mmap_sram #(
        .AW (13),
        .DW (8)
    ) u_sram (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_en     (go_sram),
        .i_we     (we),
        .i_addr   (sram_a),
        .i_wdata  (wdata),
        .o_rdata  (sram_rdata)
    );

    mmap_sfr u_sfr (
        .i_clk         (i_clk),
        .i_resetn      (i_resetn),
        .i_go          (go_sfr),
        .i_we          (we),
        .i_idx         (sfr_idx),
        .i_wdata       (wdata),
        .i_bit         (bit_acc),
        .i_bitsel      (i_data_bitsel),
        .i_window      (!g_data),
        .o_sfr_rd      (o_sfr_rd),
        .o_sfr_wr      (o_sfr_wr),
        .o_sfr_addr    (o_sfr_addr),
        .o_sfr_wdata   (o_sfr_wdata),
        .o_sfr_wmask   (o_sfr_wmask),
        .o_local       (sfr_local),
        .o_local_rdata (sfr_lrdata),
        .o_unified     (unified),
        .o_bank        (bank)
    );

    // ------------------------------------------------------------
    // Answer stage
    // ------------------------------------------------------------
    // Unmapped regions and writes answer with zero; masters must not
    // read meaning into it.
    wire [7:0] raw = (tgt_ff == mmap_pkg::TGT_FLASH) ? i_flash_rdata
                   : (tgt_ff == mmap_pkg::TGT_SRAM)  ? sram_rdata
                   : (tgt_ff == mmap_pkg::TGT_RADIO) ? i_radio_rdata
                   : (tgt_ff == mmap_pkg::TGT_SFR)
                     ? (sfr_local ? sfr_lrdata : i_sfr_rdata)
                   : 8'h00;
    wire [7:0] res = !rd_ff ? 8'h00
                   : bit_ff ? {7'h00, raw[bitsel_ff]} : raw;
    wire       done = (st_ff == mmap_pkg::ST_WAIT);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_ff     <= '0;
            code_rd_ff <= '0;
            xc_rd_ff   <= '0;
            dma_rd_ff  <= '0;
            data_rd_ff <= '0;
            stall_ff   <= 1'b0;
        end else begin
            ack_ff   <= done ? mst_ff : 4'h0;
            stall_ff <= (i_xc_req && !ack_ff[1])
                        || (!idle && mst_ff[1] && !done);
            if (done && mst_ff[0]) code_rd_ff <= res;
            if (done && mst_ff[1]) xc_rd_ff <= res;
            if (done && mst_ff[2]) dma_rd_ff <= res;
            if (done && mst_ff[3]) data_rd_ff <= res;
        end
    end

    assign o_code_ack   = ack_ff[0];
    assign o_xc_ack     = ack_ff[1];
    assign o_dma_ack    = ack_ff[2];
    assign o_data_ack   = ack_ff[3];
    assign o_code_rdata = code_rd_ff;
    assign o_xc_rdata   = xc_rd_ff;
    assign o_dma_rdata  = dma_rd_ff;
    assign o_data_rdata = data_rd_ff;
    assign o_code_stall = stall_ff;
    assign o_flash_rd   = flash_rd_ff;
    assign o_flash_addr = flash_addr_ff;
    assign o_radio_rd   = radio_rd_ff;
    assign o_radio_wr   = radio_wr_ff;
    assign o_radio_addr = radio_addr_ff;
    assign o_radio_wdata = radio_wdata_ff;
    assign o_unified_code_map_select = unified;
    assign o_flash_bank_select       = bank;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    a_fetch_waits: assert property (g_code |=> !o_code_stall)
        else $error("fetch granted during data access");
    a_stall_shows: assert property (g_xc |=> o_code_stall [*3])
        else $error("fetch stall missing during data access");
    a_std_flash: assert property ((g_code && !unified)
        |=> !o_sfr_rd && !o_radio_rd && $past(!go_sram))
        else $error("standard CODE left flash");
    a_flash_xdata: assert property ((g_xc && !i_xc_we
        && i_xc_addr < mmap_pkg::XD_RADIO_BASE
        && (FLASH_KB > 32 || !i_xc_addr[15]))
        |=> o_flash_rd && o_flash_addr == {1'b0, $past(i_xc_addr)})
        else $error("XDATA flash placement wrong");
    a_radio_win: assert property ((g_dma && !i_dma_we
        && i_dma_addr[15:7] == mmap_pkg::XD_RADIO_BASE[15:7])
        |=> o_radio_rd && o_radio_addr == $past(i_dma_addr[6:0]))
        else $error("radio window not decoded");
    a_sfr_win: assert property ((g_dma && !i_dma_we
        && i_dma_addr[15:7] == mmap_pkg::XD_SFR_BASE[15:7])
        |=> (o_sfr_rd || sfr_local)
            && o_sfr_addr == {1'b1, $past(i_dma_addr[6:0])})
        else $error("register window not decoded");
    a_bank_sel: assert property ((g_code && FLASH_KB == 128
        && i_code_addr[15] && i_code_addr < mmap_pkg::XD_RADIO_BASE)
        |=> o_flash_addr[16:15] == $past(bank))
        else $error("bank select ignored");
    a_data_sram: assert property ((g_data && !data_rf)
        |-> go_sram && sram_a == {mmap_pkg::DATA_PAGE, i_data_addr})
        else $error("data byte outside SRAM top page");
    a_sleep_hold: assert property (i_deepest_low_power_modes
        |=> !o_flash_rd && !o_radio_rd && !o_radio_wr)
        else $error("access during deepest low-power mode");
    a_dma_answer: assert property (g_dma |-> ##3 o_dma_ack)
        else $error("DMA answer not three cycles after grant");
    a_reset_std: assert property ($rose(i_resetn)
        |-> !unified && bank == 2'h0 && st_ff == mmap_pkg::ST_IDLE)
        else $error("reset left a unified or banked map");

    c_dma_sram: cover property (g_dma && tgt == mmap_pkg::TGT_SRAM);
    c_code_unified: cover property (g_code && unified
                                    && tgt == mmap_pkg::TGT_SRAM);
    c_bit_write: cover property (g_data && bit_acc && we);
    c_unmapped: cover property (g_any && tgt == mmap_pkg::TGT_NONE);
endmodule
`default_nettype wire

// ---- bench/mmap_mem_model.sv ----
// Flash, radio and register files on the far side of the mapper.
// Each answers the cycle after its read strobe and flips afterwards.
`timescale 1ns/10ps
`default_nettype none
module mmap_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_flash_rd,
    input  wire logic [16:0] i_flash_addr,
    input  wire logic        i_radio_rd,
    input  wire logic [6:0]  i_radio_addr,
    input  wire logic        i_sfr_rd,
    input  wire logic [7:0]  i_sfr_addr,
    output logic      [7:0]  o_flash_rdata,
    output logic      [7:0]  o_radio_rdata,
    output logic      [7:0]  o_sfr_rdata
);
    // Inverting stale data stops a late sample from passing by luck.
    always @(posedge i_clk) begin
        o_flash_rdata <= i_flash_rd ?
            i_flash_addr[7:0] ^ i_flash_addr[16:9] : ~o_flash_rdata;
        o_radio_rdata <= i_radio_rd ? {1'b1, i_radio_addr} : ~o_radio_rdata;
        o_sfr_rdata <= i_sfr_rd ? ~i_sfr_addr : ~o_sfr_rdata;
    end
endmodule
`default_nettype wire

// ---- bench/memory_space_address_mapper_test.sv ----
// Self-checking bench of the mapper with the 128 KB flash option.
// Assumes the memory model answers one cycle after each strobe.
`timescale 1ns/10ps
`default_nettype none
module memory_space_address_mapper_test;
    logic i_clk = 1'b0, i_resetn = 1'b0, i_deepest_low_power_modes = 1'b0;
    logic i_code_req, i_xc_req, i_xc_we, i_dma_req, i_dma_we, i_data_req;
    logic i_data_we, i_data_indirect, i_data_bit;
    logic [15:0] i_code_addr, i_xc_addr, i_dma_addr;
    logic [7:0] i_xc_wdata, i_dma_wdata, i_data_addr, i_data_wdata;
    logic [2:0] i_data_bitsel;
    logic o_code_ack, o_code_stall, o_xc_ack, o_dma_ack, o_data_ack;
    logic [7:0] o_code_rdata, o_xc_rdata, o_dma_rdata, o_data_rdata;
    logic o_flash_rd, o_radio_rd, o_radio_wr, o_sfr_rd, o_sfr_wr;
    logic [16:0] o_flash_addr;
    logic [6:0] o_radio_addr;
    logic [7:0] o_radio_wdata, o_sfr_addr, o_sfr_wdata, o_sfr_wmask;
    logic [7:0] i_flash_rdata, i_radio_rdata, i_sfr_rdata;
    logic o_unified_code_map_select;
    logic [1:0] o_flash_bank_select;
    int mismatches = 0, tests_run = 0;
    logic [7:0] seen_mask, seen_sfr_wd, seen_rad_wd;

    // Write strobes are single pulses, so their payload is caught here.
    always @(posedge i_clk) begin
        if (o_sfr_wr) {seen_mask, seen_sfr_wd} <= {o_sfr_wmask, o_sfr_wdata};
        if (o_radio_wr) seen_rad_wd <= o_radio_wdata;
    end

    mmap_top #(.FLASH_KB(128)) dut (.*);
    mmap_mem_model mem (
        .i_clk        (i_clk),
        .i_flash_rd   (o_flash_rd),
        .i_flash_addr (o_flash_addr),
        .i_radio_rd   (o_radio_rd),
        .i_radio_addr (o_radio_addr),
        .i_sfr_rd     (o_sfr_rd),
        .i_sfr_addr   (o_sfr_addr),
        .o_flash_rdata(i_flash_rdata),
        .o_radio_rdata(i_radio_rdata),
        .o_sfr_rdata  (i_sfr_rdata)
    );
    always #5 i_clk = ~i_clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask

    task automatic idle;
        {i_code_req, i_xc_req, i_dma_req, i_data_req} = 4'h0;
        {i_xc_we, i_dma_we, i_data_we, i_data_indirect, i_data_bit} = 5'h00;
        {i_code_addr, i_xc_addr, i_dma_addr, i_data_bitsel} = 51'h0;
        {i_xc_wdata, i_dma_wdata, i_data_addr, i_data_wdata} = 32'h0;
    endtask

    // Master 0 DMA, 1 CPU XDATA, 2 CODE, 3 DATA (a[8] marks indirect,
    // a[12] a single-bit access and a[11:9] the bit).
    task automatic acc(input int m, input logic we, input logic [15:0] a,
                       input logic [7:0] wd, input logic [7:0] ex);
        int n;
        logic [3:0] ak;
        logic [7:0] rd;
        @(posedge i_clk) #1;
        case (m)
            0: {i_dma_req, i_dma_we, i_dma_addr, i_dma_wdata} = {1'b1, we, a, wd};
            1: {i_xc_req, i_xc_we, i_xc_addr, i_xc_wdata} = {1'b1, we, a, wd};
            2: {i_code_req, i_code_addr} = {1'b1, a};
            default: {i_data_req, i_data_we, i_data_bit, i_data_bitsel,
                      i_data_indirect, i_data_addr, i_data_wdata}
                     = {1'b1, we, a[12], a[11:9], a[8], a[7:0], wd};
        endcase
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
            ak = {o_data_ack, o_code_ack, o_xc_ack, o_dma_ack};
            if (m == 1 && n == 2) chk({7'h00, o_code_stall}, 8'h01);
        end while (ak[m] !== 1'b1 && n < 12);
        rd = m == 0 ? o_dma_rdata : m == 1 ? o_xc_rdata :
             m == 2 ? o_code_rdata : o_data_rdata;
        #1 idle();
        if (ak[m] !== 1'b1) chk(8'hEE, 8'hAC);
        else if (!we) chk(rd, ex);
    endtask

    task automatic xdata_map;
        acc(0, 0, 16'h0010, 8'h00, 8'h10);
        acc(1, 0, 16'h0010, 8'h00, 8'h10);
        acc(0, 0, 16'hDEFF, 8'h00, 8'h90);
        acc(0, 0, 16'hDF05, 8'h00, 8'h85);
        acc(0, 0, 16'hDF90, 8'h00, 8'h6F);
        acc(0, 0, 16'hDF81, 8'h00, 8'h00);
        acc(0, 1, 16'hDF12, 8'h96, 8'h00);
        chk(seen_rad_wd, 8'h96);
        acc(0, 1, 16'hDF90, 8'h44, 8'h00);
        chk(seen_mask, 8'hFF);
        chk(seen_sfr_wd, 8'h44);
        acc(0, 1, 16'hE123, 8'hA5, 8'h00);
        acc(1, 0, 16'hE123, 8'h00, 8'hA5);
        acc(1, 1, 16'hFF05, 8'h5A, 8'h00);
        acc(3, 0, 16'h0105, 8'h00, 8'h5A);
        acc(3, 1, 16'h0011, 8'hC3, 8'h00);
        acc(0, 0, 16'hFF11, 8'h00, 8'hC3);
    endtask

    task automatic code_maps;
        acc(2, 0, 16'h1234, 8'h00, 8'h3D);
        acc(2, 0, 16'h9000, 8'h00, 8'h08);
        acc(2, 0, 16'hE123, 8'h00, 8'h13);
        acc(3, 1, 16'h00C7, 8'h70, 8'h00);
        chk({7'h00, o_unified_code_map_select}, 8'h01);
        chk({6'h00, o_flash_bank_select}, 8'h03);
        acc(3, 0, 16'h00C7, 8'h00, 8'h70);
        acc(2, 0, 16'h9000, 8'h00, 8'hC8);
        acc(2, 0, 16'h1234, 8'h00, 8'h3D);
        acc(2, 0, 16'hE123, 8'h00, 8'hA5);
        acc(2, 0, 16'hDF81, 8'h00, 8'h00);
    endtask

    task automatic bit_access;
        acc(3, 0, 16'h16C0, 8'h00, 8'h01);
        acc(3, 0, 16'h16C1, 8'h00, 8'h00);
        acc(3, 1, 16'h1AC8, 8'h01, 8'h00);
        chk(seen_mask, 8'h20);
        chk(seen_sfr_wd, 8'hFF);
    endtask

    // Deepest low-power mode holds back new grants; the retained upper
    // SRAM must still hold its byte once the mode ends.
    task automatic sleep_keep;
        acc(0, 1, 16'hF00A, 8'h3C, 8'h00);
        i_deepest_low_power_modes = 1'b1;
        fork
            begin
                repeat (6) begin
                    @(posedge i_clk);
                    chk({7'h00, o_xc_ack}, 8'h00);
                end
                #1 i_deepest_low_power_modes = 1'b0;
            end
            acc(1, 0, 16'hF00A, 8'h00, 8'h3C);
        join
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        idle();
        repeat (16) @(posedge i_clk);
        #1 i_resetn = 1'b1;
        chk({7'h00, o_unified_code_map_select}, 8'h00);
        chk({6'h00, o_flash_bank_select}, 8'h00);
        xdata_map();
        code_maps();
        bit_access();
        sleep_keep();
        give_verdict();
    end

    initial begin
        #50000;
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
